// file: rtl/kwp_window_gen.sv
// knock window pulse generator: up to eight angle windows on one output channel
// assumes angle_i is a count in hundredths of a degree from the engine position block,
// synchronous to clk_i, rising 0..71999 then wrapping
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module kwp_window_gen #(
  parameter int NUM_WIN = kwp_pkg::WIN_MAX
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // engine angle
  input  wire logic [16:0] angle_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // window output and interrupt
  output logic             win_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------------------
  logic [31:0]             ctrl, next_ctrl;
  logic [2:0]              sel, next_sel;       // one-based index minus one
  logic [16:0]             stg_open, next_stg_open;
  logic [16:0]             stg_width, next_stg_width;
  logic [1:0]              status, next_status;
  logic [1:0]              mask, next_mask;
  logic [31:0]             rdata, next_rdata;
  kwp_pkg::kwp_upd_state_t ust, next_ust;
  kwp_pkg::kwp_pair_t      pend, next_pend;      // pair held until window idle
  logic [2:0]              pend_idx, next_pend_idx;

  kwp_pkg::kwp_pair_t      tbl [NUM_WIN];
  logic [NUM_WIN-1:0]      act, next_act;
  logic                    win, next_win;

  logic                    en, pol, irq_close;
  logic [2:0]              num_m1;
  logic [NUM_WIN-1:0]      in_win, open_ev, close_ev;
  logic                    any_open, any_close, edge_ev, go_ok, commit;

  assign en        = ctrl[kwp_pkg::CTRL_EN_BIT];
  assign pol       = ctrl[kwp_pkg::CTRL_POL_BIT];
  assign irq_close = ctrl[kwp_pkg::CTRL_IRQ_BIT];
  assign num_m1    = ctrl[kwp_pkg::CTRL_NUM_LSB +: 3];

  // ---------------------------------------------------------------------------
  // window decode per entry
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_WIN; g++) begin : g_win
      logic [17:0] span;
      // distance past the open angle, modulo the cycle, avoids a wrap compare
      always_comb begin
        if (angle_i >= tbl[g].open) begin
          span = {1'b0, angle_i} - {1'b0, tbl[g].open};
        end else begin
          span = {1'b0, angle_i} + {1'b0, kwp_pkg::CYCLE_COUNTS} - {1'b0, tbl[g].open};
        end
      end
      // only the first num windows may run, never more than eight
      assign in_win[g]   = en && (g <= num_m1) && (span < {1'b0, tbl[g].width});
      assign open_ev[g]  = in_win[g] && !act[g];
      assign close_ev[g] = !in_win[g] && act[g];
    end
  endgenerate

  assign any_open  = |open_ev;
  assign any_close = |close_ev;
  assign edge_ev   = irq_close ? any_close : any_open;
  assign next_act  = in_win;
  assign next_win  = |in_win;

  // ---------------------------------------------------------------------------
  // update path
  // ---------------------------------------------------------------------------
  // range checks on the staged pair; bad values are refused, and flagged only when the update sequencer is idle
  assign go_ok  = (stg_open <= kwp_pkg::ANGLE_MAX)
               && (stg_width <= kwp_pkg::ANGLE_MAX);
  // commit waits while the target window is open so a running window keeps its shape
  assign commit = (ust == kwp_pkg::UPD_HELD) && !act[pend_idx] && !in_win[pend_idx];

  always_comb begin
    next_ust      = ust;
    next_pend     = pend;
    next_pend_idx = pend_idx;
    case (ust)
      kwp_pkg::UPD_IDLE: begin
        if (wr_i && addr_i == kwp_pkg::REG_UPD_GO && go_ok) begin
          next_pend     = '{open: stg_open, width: stg_width};
          next_pend_idx = sel;
          next_ust      = kwp_pkg::UPD_HELD;
        end
      end
      kwp_pkg::UPD_HELD: begin
        if (commit) begin
          next_ust = kwp_pkg::UPD_DONE;
        end
      end
      kwp_pkg::UPD_DONE: next_ust = kwp_pkg::UPD_IDLE;
      default:           next_ust = kwp_pkg::UPD_IDLE;
    endcase
  end

  // table write: both halves in one edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_WIN; i++) begin
        tbl[i] <= '0;
      end
    end else if (commit) begin
      tbl[pend_idx] <= pend;
    end
  end

  // ---------------------------------------------------------------------------
  // registers and read port
  // ---------------------------------------------------------------------------
  always_comb begin
    next_ctrl      = ctrl;
    next_sel       = sel;
    next_stg_open  = stg_open;
    next_stg_width = stg_width;
    next_mask      = mask;
    next_status    = status;
    next_rdata     = 32'h0000_0000;
    if (wr_i) begin
      case (addr_i)
        kwp_pkg::REG_CTRL:    next_ctrl = wdata_i & 32'h0000_0077;
        kwp_pkg::REG_UPD_SEL: next_sel = wdata_i[2:0] - 3'h1;
        kwp_pkg::REG_UPD_OPN: next_stg_open = wdata_i[16:0];
        kwp_pkg::REG_UPD_WID: next_stg_width = wdata_i[16:0];
        kwp_pkg::REG_MASK:    next_mask = wdata_i[1:0];
        kwp_pkg::REG_STATUS:  next_status = status & ~wdata_i[1:0];
        default:              next_ctrl = ctrl;
      endcase
    end
    // hardware set wins over a same-cycle clear; mask does not gate the flag
    if (edge_ev) begin
      next_status[kwp_pkg::STAT_WIN_BIT] = 1'b1;
    end
    if (wr_i && addr_i == kwp_pkg::REG_UPD_GO && ust == kwp_pkg::UPD_IDLE && !go_ok) begin
      next_status[kwp_pkg::STAT_ERR_BIT] = 1'b1;
    end
    if (rd_i) begin
      case (addr_i)
        kwp_pkg::REG_CTRL:    next_rdata = ctrl;
        kwp_pkg::REG_UPD_SEL: next_rdata = {29'h0, sel + 3'h1};
        kwp_pkg::REG_UPD_OPN: next_rdata = {15'h0, stg_open};
        kwp_pkg::REG_UPD_WID: next_rdata = {15'h0, stg_width};
        kwp_pkg::REG_STATUS:  next_rdata = {30'h0, status};
        kwp_pkg::REG_MASK:    next_rdata = {30'h0, mask};
        kwp_pkg::REG_STATE:   next_rdata = {22'h0, (ust != kwp_pkg::UPD_IDLE), win, act};
        default:              next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl      <= kwp_pkg::CTRL_RESET;
      sel       <= 3'h0;
      stg_open  <= 17'h00000;
      stg_width <= 17'h00000;
      status    <= 2'h0;
      mask      <= kwp_pkg::MASK_RESET;
      rdata     <= 32'h0000_0000;
      ust       <= kwp_pkg::UPD_IDLE;
      pend      <= '0;
      pend_idx  <= 3'h0;
      act       <= '0;
      win       <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      sel       <= next_sel;
      stg_open  <= next_stg_open;
      stg_width <= next_stg_width;
      status    <= next_status;
      mask      <= next_mask;
      rdata     <= next_rdata;
      ust       <= next_ust;
      pend      <= next_pend;
      pend_idx  <= next_pend_idx;
      act       <= next_act;
      win       <= next_win;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign rdata_o = rdata;
  assign win_o   = win ^ pol;
  assign irq_o   = |(status & mask);

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  flag_on_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    edge_ev |=> status[kwp_pkg::STAT_WIN_BIT])
    else $error("window flag not set after edge");
  open_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!irq_close && any_open) |=> status[kwp_pkg::STAT_WIN_BIT])
    else $error("open edge did not set flag");
  flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (status[0] && !(wr_i && addr_i == kwp_pkg::REG_STATUS && wdata_i[0])) |=> status[0])
    else $error("flag dropped without clear");
  no_mid_update_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (act[pend_idx] || in_win[pend_idx]) |=> (tbl[$past(pend_idx)] == $past(tbl[pend_idx])))
    else $error("update landed in open window");
  pair_commit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    commit |=> (tbl[$past(pend_idx)] == $past(pend)))
    else $error("pair not written whole");
  range_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ust == kwp_pkg::UPD_IDLE && wr_i && addr_i == kwp_pkg::REG_UPD_GO && !go_ok)
      |=> ust == kwp_pkg::UPD_IDLE)
    else $error("out of range update accepted");
  win_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (act >> (num_m1 + 3'h1)) == '0 || num_m1 == 3'h7)
    else $error("window beyond count active");
  polarity_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(|act) |-> win_o == pol)
    else $error("idle level wrong");
  close_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (irq_close && any_close) |=> status[kwp_pkg::STAT_WIN_BIT])
    else $error("close edge did not set flag");
  rdata_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data stood past its cycle");

endmodule : kwp_window_gen

// file: shared/kwp_pkg.sv
// constants, field layouts and register map of the knock window pulse generator
// assumes a plain register port on clk_i and an angle count from the engine position block
//
// Contract
// - open angle and width move into window storage together as one pair
// - an accepted update takes effect at that window's next opening, never mid-window
// - a new open angle lies from 0 to 71999 hundredths of a degree
// - a new width lies from 0 to 71999 hundredths of a degree
// - the window flag sets on the chosen edge even when masked, and stays pending
// - the pending flag shows in the channel interrupt status register
// - with open-edge selection the flag sets each time a window opens
// - one to eight windows per 720 degree cycle, never more than eight
// - a setting selects active high or active low output polarity
// - a setting selects whether the flag rises at window open or close
// - angles are integers in hundredths of a degree
package kwp_pkg;

  // ---------------------------------------------------------------------------
  // angle scale
  // ---------------------------------------------------------------------------
  localparam int          ANGLE_W      = 17;
  localparam logic [16:0] ANGLE_MAX    = 17'h1193f;  // 71999, i.e. 719.99 degrees
  localparam logic [16:0] CYCLE_COUNTS = 17'h11940;  // 72000 counts per engine cycle
  localparam int          WIN_MAX      = 8;
  localparam int          IDX_W        = 3;

  // ---------------------------------------------------------------------------
  // register map, byte offsets on the plain register port
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_UPD_SEL = 8'h04;
  localparam logic [7:0] REG_UPD_OPN = 8'h08;
  localparam logic [7:0] REG_UPD_WID = 8'h0c;
  localparam logic [7:0] REG_UPD_GO  = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  localparam logic [7:0] REG_MASK    = 8'h18;
  localparam logic [7:0] REG_STATE   = 8'h1c;

  // control fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_POL_BIT  = 1;   // 0 active_high_select, 1 active_low_select
  localparam int CTRL_IRQ_BIT  = 2;   // 0 irq_on_window_open, 1 irq_on_window_close
  localparam int CTRL_NUM_LSB  = 4;   // number of windows minus one, 3 bits
  // status fields
  localparam int STAT_WIN_BIT  = 0;   // window edge event
  localparam int STAT_ERR_BIT  = 1;   // update refused for range

  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0]  MASK_RESET = 2'h0;

  // update sequencer states
  typedef enum logic [2:0] {
    UPD_IDLE = 3'b001,
    UPD_HELD = 3'b010,
    UPD_DONE = 3'b100
  } kwp_upd_state_t;

  // one window entry
  typedef struct packed {
    logic [16:0] open;
    logic [16:0] width;
  } kwp_pair_t;

endpackage : kwp_pkg

// file: testbench/kwp_angle_src.sv
// angle clock model standing in for the crank and cam position logic
// assumes one clock; hold_i freezes the angle to play a slowly turning engine
`timescale 1ns/1ps
module kwp_angle_src #(
  parameter int STEP = 100
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // stall request and angle
  input  wire logic        hold_i,
  output logic      [16:0] angle_o
);
  logic [16:0] next_angle;

  // step in hundredths of a degree and wrap at the end of the 720 degree cycle
  assign next_angle = angle_o + 17'(STEP);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      angle_o <= 17'h0;
    end else if (!hold_i) begin
      angle_o <= (next_angle >= kwp_pkg::CYCLE_COUNTS) ? next_angle - kwp_pkg::CYCLE_COUNTS
                                                      : next_angle;
    end
  end
endmodule : kwp_angle_src

// file: testbench/kwp_window_gen_tb.sv
// bench for the knock window pulse generator: registers, windows, flags
// assumes the angle model steps 100 counts per clock, so one cycle is 720 clocks
`timescale 1ns/1ps
module kwp_window_gen_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        hold = 1'b0;
  logic        chk = 1'b0;
  logic        pol = 1'b0;
  logic        rd_d = 1'b0;
  logic [7:0]  addr_i = 8'h0;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] rdata_o;
  logic [16:0] angle_i;
  logic [16:0] a_q = 17'h0;
  logic        win_o;
  logic        irq_o;
  int          t_o [8];
  int          t_w [8];
  logic [31:0] q [$];
  int          fails = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          seed = 50;
  int          num = 1;
  int          o;
  int          w;

  kwp_angle_src i_src (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold), .angle_o(angle_i));
  kwp_window_gen i_dut (.clk_i(clk_i), .rst_i(rst_i), .angle_i(angle_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .win_o(win_o), .irq_o(irq_o));

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // window model: any enabled entry covering the angle, modulo the cycle
  function automatic logic in_model(input logic [16:0] a);
    logic r;
    r = 1'b0;
    for (int i = 0; i < num; i++) begin
      if ((int'(a) + 72000 - t_o[i]) % 72000 < t_w[i]) r = 1'b1;
    end
    return r;
  endfunction : in_model

  // strobes get a idle cycle after them so no signal is driven twice in one step
  task automatic wr(input logic [7:0] a, input int d);
    addr_i <= a;
    wdata_i <= 32'(d);
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input int exp);
    addr_i <= a;
    rd_i <= 1'b1;
    q.push_back(32'(exp));
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask : rd

  task automatic load(input int i, input int op, input int wd);
    wr(8'h04, i);
    wr(8'h08, op);
    wr(8'h0c, wd);
    wr(8'h10, 1);
  endtask : load

  // window checks pause while control changes land
  task automatic ctl(input int n, input logic p, input logic c, input logic en);
    chk = 1'b0;
    wr(8'h00, {25'h0, 3'(n - 1), 1'b0, c, p, en});
    num = n;
    pol = p;
    chk = en;
  endtask : ctl

  task automatic at(input int a);
    while (angle_i !== 17'(a)) @(posedge clk_i);
  endtask : at

  // note the angle and read strobe each edge; a hang ends the run
  always @(posedge clk_i) begin
    a_q = angle_i;
    rd_d = rd_i;
    cyc++;
    if (cyc == 40000) begin
      fails++;
      print_verdict();
    end
  end

  // outputs are compared mid-cycle, once the edge updates have landed
  always @(negedge clk_i) begin
    if (rd_d) check(rdata_o, q.pop_front());
    if (chk) check(32'(win_o), 32'(in_model(a_q) ^ pol));
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h00, 0);
    rd(8'h18, 0);
    rd(8'h24, 0);
    load(1, 10000, 5000);
    load(2, 20000, 5000);
    rd(8'h04, 2);
    t_o[0] = 10000;
    t_w[0] = 5000;
    t_o[1] = 20000;
    t_w[1] = 5000;
    $display("test reset and load done");
    // masked flag still sets at the opening edge, then the mask lets it out
    ctl(2, 1'b0, 1'b0, 1'b1);
    at(5000);
    wr(8'h14, 3);
    at(12000);
    rd(8'h14, 1);
    check(32'(irq_o), 32'h0);
    wr(8'h18, 1);
    check(32'(irq_o), 32'h1);
    wr(8'h14, 1);
    check(32'(irq_o), 32'h0);
    $display("test open flag done");
    // active low output and flag on closing
    ctl(2, 1'b1, 1'b1, 1'b1);
    at(5000);
    wr(8'h14, 3);
    at(12000);
    rd(8'h14, 0);
    at(16000);
    rd(8'h14, 1);
    $display("test close flag done");
    // new pair sent in mid-window waits for the window to close, then moves whole
    wr(8'h04, 1);
    wr(8'h08, 11000);
    wr(8'h0c, 1000);
    at(12000);
    wr(8'h10, 1);
    rd(8'h1c, 32'h301);
    at(16000);
    t_o[0] = 11000;
    t_w[0] = 1000;
    at(0);
    at(16000);
    $display("test coherent update done");
    // out of range values are refused, the top value is taken and wraps
    wr(8'h14, 3);
    load(2, 72000, 100);
    rd(8'h14, 2);
    wr(8'h14, 3);
    load(2, 100, 72000);
    rd(8'h14, 2);
    wr(8'h14, 3);
    load(2, 71999, 200);
    // window two is closed here, so the pair lands at once
    t_o[1] = 71999;
    t_w[1] = 200;
    rd(8'h14, 0);
    at(26000);
    at(1000);
    $display("test range done");
    // random tables, one slot of 90 degrees each so none overlap, three enabled, engine stalling
    ctl(1, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      o = i * 9000 + $unsigned($random(seed)) % 6000;
      w = $unsigned($random(seed)) % 3000;
      load(i + 1, o, w);
      t_o[i] = o;
      t_w[i] = w;
    end
    ctl(3, 1'b0, 1'b0, 1'b1);
    repeat (2000) begin
      hold <= 1'($random(seed));
      @(posedge clk_i);
    end
    $display("test random done");
    print_verdict();
  end
endmodule : kwp_window_gen_tb
